/* hdl/uflc_uart.sv */
/*
  Serial port core with 8-byte receive and transmit FIFOs, DMA requests,
  CTS/RTS auto flow, FIFO and line control, and per-source interrupt lines.
  Assumes a plain register port on the system clock and asynchronous
  serial pins, which are synchronised here before use.
*/
`timescale 1ns/10ps
module uflc_uart
  import uflc_pkg::*;
#(
  parameter int unsigned DEPTH = 8
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire uflc_req_s   reg_req_i,
  output logic [31:0]      rdata_o,
  input  wire logic        rxd_i,
  input  wire logic        cts_i,
  output logic             txd_o,
  output logic             rts_o,
  output logic             dma_rx_req_o,
  output logic             dma_tx_req_o,
  output logic [7:0]       irq_o
);

  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || DEPTH > 32 || (1 << PW) != DEPTH) begin : g_depth_check
    $error("DEPTH must be a power of two from 2 to 32");
  end

  typedef struct packed {
    logic [DEPTH-1:0][7:0] tx_mem;
    logic [DEPTH-1:0][7:0] rx_mem;
    logic [PW-1:0]  tx_rd;
    logic [PW-1:0]  tx_wr;
    logic [CW-1:0]  tx_cnt;
    logic [PW-1:0]  rx_rd;
    logic [PW-1:0]  rx_wr;
    logic [CW-1:0]  rx_cnt;
    logic [31:0]    irq_enable;
    logic [31:0]    timeout_control;
    logic [31:0]    baud;
    logic [31:0]    infrared_control;
    logic [31:0]    lin;
    logic [31:0]    func;
    logic [6:0]     line_control;
    logic [3:0]     rts_lvl;
    logic [3:0]     rx_lvl;
    logic [1:0]     tfl_cnt;
    logic [1:0]     rfl_cnt;
    logic           rts_set;
    logic           rts_act;
    logic           cts_act;
    logic           dctsf;
    logic           tx_ovf;
    logic           rx_ovf;
    logic           bif;
    logic           fef;
    logic           pef;
    logic           lin_brk;
    logic           tout_if;
    logic [1:0]     rx_sync;
    logic [1:0]     cts_sync;
    logic           rx_prev;
    logic           cts_prev;
    logic [15:0]    div_cnt;
    logic           tick;
    uflc_tx_e       tx_st;
    logic [5:0]     tx_tck;
    logic [2:0]     tx_bit;
    logic [7:0]     tx_sh;
    logic           tx_par;
    logic           tx_line;
    uflc_rx_e       rx_st;
    logic [3:0]     rx_tck;
    logic [2:0]     rx_bit;
    logic [7:0]     rx_sh;
    logic           rx_pbit;
    logic           rx_pbad;
    logic [11:0]    to_cnt;
    logic [31:0]    rdata;
    logic           txd;
    logic           rts;
    logic           dma_rx;
    logic           dma_tx;
    logic [7:0]     irq;
  } uflc_state_s;

  function automatic uflc_state_s rst_val();
    rst_val         = '0;
    rst_val.baud    = RST_BAUD;
    rst_val.infrared_control    = RST_INFRARED_CONTROL;
    rst_val.rx_sync = 2'h3;
    rst_val.rx_prev = 1'b1;
    rst_val.tx_line = 1'b1;
    rst_val.txd     = 1'b1;
    rst_val.rts     = 1'b1;
  endfunction : rst_val

  localparam uflc_state_s ST_RST = rst_val();

  uflc_state_s s_reg;
  uflc_state_s s_next;

  logic        wr_data;
  logic        rd_data;
  logic        wr_fcr;
  logic        tx_full;
  logic        tx_empty;
  logic        rx_full;
  logic        rx_empty;
  logic        tx_push;
  logic        tx_start;
  logic        rx_done;
  logic        rx_pop;
  logic        rx_in;
  logic        cts_on;
  logic [2:0]  last_bit;
  logic [7:0]  wmask;
  logic [5:0]  stop_tck;
  logic [7:0]  flags;
  logic [7:0]  ien;
  logic [7:0]  rx_head;
  logic [7:0]  tx_head;
  logic [11:0] to_limit;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and derived terms
  assign wr_data  = reg_req_i.wr && (reg_req_i.addr == OFS_DATA);
  assign rd_data  = reg_req_i.rd && (reg_req_i.addr == OFS_DATA);
  assign wr_fcr   = reg_req_i.wr && (reg_req_i.addr == OFS_FCR);
  assign tx_full  = (s_reg.tx_cnt == CW'(DEPTH));
  assign tx_empty = (s_reg.tx_cnt == '0);
  assign rx_full  = (s_reg.rx_cnt == CW'(DEPTH));
  assign rx_empty = (s_reg.rx_cnt == '0);
  assign rx_in    = s_reg.rx_sync[1];
  assign cts_on   = (s_reg.cts_sync[1] == s_reg.cts_act);
  assign rx_head  = s_reg.rx_mem[s_reg.rx_rd];
  assign tx_head  = s_reg.tx_mem[s_reg.tx_rd];
  assign last_bit = {1'b0, s_reg.line_control[1:0]} + 3'h4;
  assign wmask    = 8'hff >> (2'h3 - s_reg.line_control[1:0]);
  assign stop_tck = !s_reg.line_control[LCR_NSB] ? TCK_BIT :
                    (s_reg.line_control[1:0] == 2'h0) ? TCK_STOP_1P5 : TCK_STOP_2;
  assign tx_push  = wr_data && !tx_full && (s_reg.tfl_cnt == '0);
  assign tx_start = (s_reg.tx_st == TX_IDLE) && s_reg.tick && !tx_empty &&
                    (s_reg.tfl_cnt == '0) &&
                    (cts_on || !s_reg.irq_enable[IER_AUTO_CTS]);
  assign rx_done  = (s_reg.rx_st == RX_STOP) && s_reg.tick && (s_reg.rx_tck == TCK_LAST);
  assign rx_pop   = rd_data && !rx_empty && (s_reg.rfl_cnt == '0);
  assign to_limit = {s_reg.timeout_control[7:0], 4'h0};
  assign flags    = {s_reg.lin_brk, 1'b0, s_reg.tx_ovf | s_reg.rx_ovf, s_reg.tout_if,
                     s_reg.dctsf, s_reg.bif | s_reg.fef | s_reg.pef, tx_empty,
                     {2'b0, s_reg.rx_cnt} >= uflc_trig(s_reg.rx_lvl)};
  assign ien      = {s_reg.irq_enable[IER_LIN_BRK], 1'b0, s_reg.irq_enable[5:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.rx_sync  = {s_reg.rx_sync[0], rxd_i};
    s_next.cts_sync = {s_reg.cts_sync[0], cts_i};
    s_next.rx_prev  = rx_in;
    s_next.cts_prev = s_reg.cts_sync[1];
    s_next.tick     = ({1'b0, s_reg.div_cnt} == {1'b0, s_reg.baud[15:0]} + 17'h1);
    s_next.div_cnt  = s_next.tick ? 16'h0 : s_reg.div_cnt + 16'h1;

    // Register writes; clears come first so hardware sets below win
    if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        OFS_IER:  s_next.irq_enable = reg_req_i.wdata & IER_MASK;
        OFS_FCR: begin
          s_next.rts_lvl = reg_req_i.wdata[FCR_RTS_LSB +: 4];
          s_next.rx_lvl  = reg_req_i.wdata[FCR_RX_IRQ_THRESHOLD_LSB +: 4];
        end
        OFS_LCR:  s_next.line_control = reg_req_i.wdata[6:0];
        OFS_MCR: begin
          s_next.rts_act = reg_req_i.wdata[MCR_RTS_ACT];
          s_next.rts_set = reg_req_i.wdata[MCR_RTS_SET];
        end
        OFS_MSR: begin
          s_next.cts_act = reg_req_i.wdata[MSR_CTS_ACT];
          if (reg_req_i.wdata[MSR_DCTSF]) s_next.dctsf = 1'b0;
        end
        OFS_FSR: begin
          if (reg_req_i.wdata[FSR_TX_OVF]) s_next.tx_ovf = 1'b0;
          if (reg_req_i.wdata[FSR_RX_OVF]) s_next.rx_ovf = 1'b0;
          if (reg_req_i.wdata[FSR_BIF])    s_next.bif    = 1'b0;
          if (reg_req_i.wdata[FSR_FEF])    s_next.fef    = 1'b0;
          if (reg_req_i.wdata[FSR_PEF])    s_next.pef    = 1'b0;
        end
        OFS_ISR: begin
          if (reg_req_i.wdata[ISR_LIN_BRK]) s_next.lin_brk = 1'b0;
          if (reg_req_i.wdata[ISR_TOUT])    s_next.tout_if = 1'b0;
        end
        OFS_TOR:  s_next.timeout_control  = reg_req_i.wdata;
        OFS_BAUD: s_next.baud = reg_req_i.wdata;
        OFS_INFRARED_CONTROL: s_next.infrared_control = reg_req_i.wdata;
        OFS_LIN:  s_next.lin  = reg_req_i.wdata;
        OFS_FUNC: s_next.func = reg_req_i.wdata;
        default: ;
      endcase
    end

    // Transmit path
    if (wr_data && tx_full) s_next.tx_ovf = 1'b1;
    if (tx_push) begin
      s_next.tx_mem[s_reg.tx_wr] = reg_req_i.wdata[7:0];
      s_next.tx_wr = s_reg.tx_wr + PW'(1);
    end
    if (s_reg.tick && s_reg.tx_st != TX_IDLE) s_next.tx_tck = s_reg.tx_tck + 6'h1;
    unique case (s_reg.tx_st)
      TX_IDLE: if (tx_start) begin
        s_next.tx_sh   = tx_head & wmask;
        s_next.tx_par  = s_reg.line_control[LCR_SPE] ? !s_reg.line_control[LCR_EPE] :
                         (^(tx_head & wmask)) ^ !s_reg.line_control[LCR_EPE];
        s_next.tx_rd   = s_reg.tx_rd + PW'(1);
        s_next.tx_st   = TX_START;
        s_next.tx_tck  = 6'h0;
        s_next.tx_line = 1'b0;
      end
      TX_START: if (s_reg.tick && s_reg.tx_tck == TCK_BIT - 6'h1) begin
        s_next.tx_st   = TX_DATA;
        s_next.tx_tck  = 6'h0;
        s_next.tx_bit  = 3'h0;
        s_next.tx_line = s_reg.tx_sh[0];
      end
      TX_DATA: if (s_reg.tick && s_reg.tx_tck == TCK_BIT - 6'h1) begin
        s_next.tx_tck = 6'h0;
        if (s_reg.tx_bit == last_bit) begin
          s_next.tx_st   = s_reg.line_control[LCR_PBE] ? TX_PAR : TX_STOP;
          s_next.tx_line = s_reg.line_control[LCR_PBE] ? s_reg.tx_par : 1'b1;
        end else begin
          s_next.tx_bit  = s_reg.tx_bit + 3'h1;
          s_next.tx_sh   = s_reg.tx_sh >> 1;
          s_next.tx_line = s_reg.tx_sh[1];
        end
      end
      TX_PAR: if (s_reg.tick && s_reg.tx_tck == TCK_BIT - 6'h1) begin
        s_next.tx_st   = TX_STOP;
        s_next.tx_tck  = 6'h0;
        s_next.tx_line = 1'b1;
      end
      TX_STOP: if (s_reg.tick && s_reg.tx_tck == stop_tck - 6'h1) begin
        s_next.tx_st = TX_IDLE;
      end
    endcase
    s_next.tx_cnt = s_reg.tx_cnt + CW'(tx_push) - CW'(tx_start);

    // Receive path; a half-bit recheck rejects false starts
    if (s_reg.tick && s_reg.rx_st != RX_IDLE) s_next.rx_tck = s_reg.rx_tck + 4'h1;
    unique case (s_reg.rx_st)
      RX_IDLE: if (!rx_in && s_reg.rx_prev) begin
        s_next.rx_st  = RX_START;
        s_next.rx_tck = 4'h0;
      end
      RX_START: if (s_reg.tick && s_reg.rx_tck == TCK_HALF) begin
        s_next.rx_st   = rx_in ? RX_IDLE : RX_DATA;
        s_next.rx_tck  = 4'h0;
        s_next.rx_bit  = 3'h0;
        s_next.rx_sh   = 8'h00;
        s_next.rx_pbit = 1'b0;
        s_next.rx_pbad = 1'b0;
      end
      RX_DATA: if (s_reg.tick && s_reg.rx_tck == TCK_LAST) begin
        s_next.rx_sh[s_reg.rx_bit] = rx_in;
        s_next.rx_bit = s_reg.rx_bit + 3'h1;
        if (s_reg.rx_bit == last_bit)
          s_next.rx_st = s_reg.line_control[LCR_PBE] ? RX_PAR : RX_STOP;
      end
      RX_PAR: if (s_reg.tick && s_reg.rx_tck == TCK_LAST) begin
        s_next.rx_st   = RX_STOP;
        s_next.rx_pbit = rx_in;
        s_next.rx_pbad = rx_in != (s_reg.line_control[LCR_SPE] ? !s_reg.line_control[LCR_EPE] :
                         (^s_reg.rx_sh) ^ !s_reg.line_control[LCR_EPE]);
      end
      RX_STOP: if (rx_done) begin
        s_next.rx_st = RX_IDLE;
        if (s_reg.rx_pbad) s_next.pef = 1'b1;
        if (!rx_in && s_reg.rx_sh == 8'h00 && !s_reg.rx_pbit) begin
          s_next.bif = 1'b1;
          if (s_reg.lin[LIN_RX_EN]) s_next.lin_brk = 1'b1;
        end else if (!rx_in) begin
          s_next.fef = 1'b1;
        end
        if (rx_full) s_next.rx_ovf = 1'b1;
        else if (s_reg.rfl_cnt == '0) begin
          s_next.rx_mem[s_reg.rx_wr] = s_reg.rx_sh;
          s_next.rx_wr = s_reg.rx_wr + PW'(1);
        end
      end
    endcase
    if (rx_pop) s_next.rx_rd = s_reg.rx_rd + PW'(1);
    s_next.rx_cnt = s_reg.rx_cnt + CW'(rx_done && !rx_full && s_reg.rfl_cnt == '0)
                    - CW'(rx_pop);

    // FIFO flushes hold their side in reset for three cycles
    if (s_reg.tfl_cnt != '0) s_next.tfl_cnt = s_reg.tfl_cnt - 2'h1;
    if (s_reg.rfl_cnt != '0) s_next.rfl_cnt = s_reg.rfl_cnt - 2'h1;
    if (wr_fcr && reg_req_i.wdata[FCR_TFR]) s_next.tfl_cnt = FLUSH_CYCLES;
    if (wr_fcr && reg_req_i.wdata[FCR_RFR]) s_next.rfl_cnt = FLUSH_CYCLES;
    if (s_next.tfl_cnt != '0) begin
      s_next.tx_rd   = '0;
      s_next.tx_wr   = '0;
      s_next.tx_cnt  = '0;
      s_next.tx_st   = TX_IDLE;
      s_next.tx_line = 1'b1;
    end
    if (s_next.rfl_cnt != '0) begin
      s_next.rx_rd  = '0;
      s_next.rx_wr  = '0;
      s_next.rx_cnt = '0;
      s_next.rx_st  = RX_IDLE;
    end

    // Receive timeout and modem change
    if (!s_reg.irq_enable[IER_TOC] || s_next.rx_cnt == '0 || s_reg.rx_st != RX_IDLE ||
        rx_pop || rx_done) begin
      s_next.to_cnt = 12'h0;
    end else if (s_reg.tick && s_reg.to_cnt != to_limit) begin
      s_next.to_cnt = s_reg.to_cnt + 12'h1;
    end
    // Clear by a data read first, so a timeout in the same cycle still wins
    if (rx_pop) s_next.tout_if = 1'b0;
    if (s_reg.irq_enable[IER_TOC] && s_reg.timeout_control[7:0] != 8'h00 && s_reg.to_cnt == to_limit)
      s_next.tout_if = 1'b1;
    if (s_reg.cts_sync[1] != s_reg.cts_prev) s_next.dctsf = 1'b1;

    // Registered outputs
    s_next.txd    = s_next.line_control[LCR_BCB] ? 1'b0 : s_next.tx_line;
    s_next.rts    = (s_reg.irq_enable[IER_AUTO_RTS] ?
                    ({2'b0, s_reg.rx_cnt} < uflc_trig(s_reg.rts_lvl)) :
                    s_reg.rts_set) ? s_reg.rts_act : !s_reg.rts_act;
    s_next.dma_rx = s_reg.irq_enable[IER_DMA_RX] && !rx_empty;
    s_next.dma_tx = s_reg.irq_enable[IER_DMA_TX] && !tx_full;
    s_next.irq    = flags & ien;

    // Read data stands in the cycle after the strobe only
    s_next.rdata = 32'h0;
    if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        OFS_DATA: s_next.rdata = rx_empty ? 32'h0 : {24'h0, rx_head};
        OFS_IER:  s_next.rdata = s_reg.irq_enable;
        OFS_FCR:  s_next.rdata = {12'h0, s_reg.rts_lvl, 8'h0, s_reg.rx_lvl, 1'b0,
                                  s_reg.tfl_cnt != '0, s_reg.rfl_cnt != '0, 1'b0};
        OFS_LCR:  s_next.rdata = {25'h0, s_reg.line_control};
        OFS_MCR:  s_next.rdata = {18'h0, s_reg.rts, 3'h0, s_reg.rts_act, 7'h0,
                                  s_reg.rts_set, 1'b0};
        OFS_MSR:  s_next.rdata = {23'h0, s_reg.cts_act, 3'h0, s_reg.cts_sync[1], 3'h0,
                                  s_reg.dctsf};
        OFS_FSR:  s_next.rdata = {3'h0, tx_empty && s_reg.tx_st == TX_IDLE, 3'h0,
                                  s_reg.tx_ovf, tx_full, tx_empty, 6'(s_reg.tx_cnt),
                                  rx_full, rx_empty, 6'(s_reg.rx_cnt), 1'b0,
                                  s_reg.bif, s_reg.fef, s_reg.pef, 3'h0, s_reg.rx_ovf};
        OFS_ISR:  s_next.rdata = {16'h0, flags & ien, flags};
        OFS_TOR:  s_next.rdata = s_reg.timeout_control;
        OFS_BAUD: s_next.rdata = s_reg.baud;
        OFS_INFRARED_CONTROL: s_next.rdata = s_reg.infrared_control;
        OFS_LIN:  s_next.rdata = s_reg.lin;
        OFS_FUNC: s_next.rdata = s_reg.func;
        default:  s_next.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= ST_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_o      = s_reg.rdata;
  assign txd_o        = s_reg.txd;
  assign rts_o        = s_reg.rts;
  assign dma_rx_req_o = s_reg.dma_rx;
  assign dma_tx_req_o = s_reg.dma_tx;
  assign irq_o        = s_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence seq_tfr_write;
    wr_fcr && reg_req_i.wdata[FCR_TFR];
  endsequence
  sequence seq_rfr_write;
    wr_fcr && reg_req_i.wdata[FCR_RFR];
  endsequence

  rx_pop_data_a: assert property (rx_pop |=> rdata_o == {24'h0, $past(rx_head)})
    else $error("data read did not return oldest byte");
  tx_push_cnt_a: assert property (tx_push && !tx_start && !wr_fcr |=>
    s_reg.tx_cnt == $past(s_reg.tx_cnt) + CW'(1)) else $error("push lost");
  dma_rx_req_a: assert property (dma_rx_req_o == $past(s_reg.irq_enable[IER_DMA_RX] && !rx_empty))
    else $error("rx dma request wrong");
  dma_tx_req_a: assert property (##1 dma_tx_req_o ==
    $past(s_reg.irq_enable[IER_DMA_TX] && !tx_full)) else $error("tx dma request wrong");
  cts_hold_a: assert property (s_reg.irq_enable[IER_AUTO_CTS] && !cts_on &&
    s_reg.tx_st == TX_IDLE |=> s_reg.tx_st == TX_IDLE) else $error("sent without cts");
  rts_deassert_a: assert property (s_reg.irq_enable[IER_AUTO_RTS] &&
    {2'b0, s_reg.rx_cnt} >= uflc_trig(s_reg.rts_lvl) |=> rts_o == !$past(s_reg.rts_act))
    else $error("rts still asserted at level");
  toc_off_a: assert property (!s_reg.irq_enable[IER_TOC] |=> s_reg.to_cnt == 12'h0)
    else $error("timeout counter ran while disabled");
  irq_gate_a: assert property (##1 irq_o == ($past(flags) & $past(ien)))
    else $error("interrupt line not flag and enable");
  tx_flush_a: assert property (seq_tfr_write |=> (s_reg.tfl_cnt != '0)[*3]
    ##1 (s_reg.tfl_cnt == '0 && s_reg.tx_cnt == '0)) else $error("tx flush timing");
  rx_flush_a: assert property (seq_rfr_write |=> (s_reg.rx_cnt == '0)[*3]
    ##1 s_reg.rfl_cnt == '0) else $error("rx flush timing");
  break_force_a: assert property (s_reg.line_control[LCR_BCB] && !$past(s_reg.line_control[LCR_BCB])
    |-> !txd_o) else $error("break did not force space");

endmodule : uflc_uart

/* inc/uflc_pkg.sv */
/*
  Package of the FIFO and line-control serial port: register offsets, field
  positions, reset values, timing constants, state enums and the bus carrier.
  Assumes one system clock drives both the register side and the serial engine.
*/
package uflc_pkg;

  localparam int unsigned ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_DATA  = 8'h00;
  localparam logic [7:0] OFS_IER   = 8'h04;
  localparam logic [7:0] OFS_FCR   = 8'h08;
  localparam logic [7:0] OFS_LCR   = 8'h0c;
  localparam logic [7:0] OFS_MCR   = 8'h10;
  localparam logic [7:0] OFS_MSR   = 8'h14;
  localparam logic [7:0] OFS_FSR   = 8'h18;
  localparam logic [7:0] OFS_ISR   = 8'h1c;
  localparam logic [7:0] OFS_TOR   = 8'h20;
  localparam logic [7:0] OFS_BAUD  = 8'h24;
  localparam logic [7:0] OFS_INFRARED_CONTROL  = 8'h28;
  localparam logic [7:0] OFS_LIN   = 8'h2c;
  localparam logic [7:0] OFS_FUNC  = 8'h30;

  // irq_enable fields
  localparam int unsigned IER_DMA_RX   = 15;
  localparam int unsigned IER_DMA_TX   = 14;
  localparam int unsigned IER_AUTO_CTS = 13;
  localparam int unsigned IER_AUTO_RTS = 12;
  localparam int unsigned IER_TOC      = 11;
  localparam int unsigned IER_LIN_BRK  = 8;
  localparam logic [31:0] IER_MASK     = 32'h0000f93f;

  // fifo_control, line_control, modem, status, interrupt and LIN fields
  localparam int unsigned FCR_RTS_LSB  = 16;
  localparam int unsigned FCR_RX_IRQ_THRESHOLD_LSB = 4;
  localparam int unsigned FCR_TFR      = 2;
  localparam int unsigned FCR_RFR      = 1;
  localparam int unsigned LCR_BCB      = 6;
  localparam int unsigned LCR_SPE      = 5;
  localparam int unsigned LCR_EPE      = 4;
  localparam int unsigned LCR_PBE      = 3;
  localparam int unsigned LCR_NSB      = 2;
  localparam int unsigned MCR_RTS_ST   = 13;
  localparam int unsigned MCR_RTS_ACT  = 9;
  localparam int unsigned MCR_RTS_SET  = 1;
  localparam int unsigned MSR_CTS_ACT  = 8;
  localparam int unsigned MSR_CTS_ST   = 4;
  localparam int unsigned MSR_DCTSF    = 0;
  localparam int unsigned FSR_TX_OVF   = 24;
  localparam int unsigned FSR_BIF      = 6;
  localparam int unsigned FSR_FEF      = 5;
  localparam int unsigned FSR_PEF      = 4;
  localparam int unsigned FSR_RX_OVF   = 0;
  localparam int unsigned ISR_LIN_BRK  = 7;
  localparam int unsigned ISR_TOUT     = 4;
  localparam int unsigned LIN_RX_EN    = 0;

  // Reset values
  localparam logic [31:0] RST_BAUD = 32'h0f000000;
  localparam logic [31:0] RST_INFRARED_CONTROL = 32'h00000040;

  // Timing in cycles of the 16x oversampling tick; FLUSH_CYCLES counts system clocks
  localparam logic [1:0] FLUSH_CYCLES = 2'h3;
  localparam logic [5:0] TCK_BIT      = 6'h10;
  localparam logic [5:0] TCK_STOP_1P5 = 6'h18;
  localparam logic [5:0] TCK_STOP_2   = 6'h20;
  localparam logic [3:0] TCK_HALF     = 4'h7;
  localparam logic [3:0] TCK_LAST     = 4'hf;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uflc_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uflc_rx_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } uflc_req_s;

  // Trigger code to byte count; unlisted codes saturate at a full FIFO
  function automatic logic [5:0] uflc_trig(input logic [3:0] code);
    case (code)
      4'h0:    uflc_trig = 6'h01;
      4'h1:    uflc_trig = 6'h04;
      default: uflc_trig = 6'h08;
    endcase
  endfunction : uflc_trig

endpackage : uflc_pkg

/* tb/tb.sv */
/* Bench for the serial port: register reset reads, tx, rx, flush, break.
   Assumes reset baud divisor and the uflc_peer serial model. */
`timescale 1ns/10ps
module tb;
  import uflc_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] v;} uflc_row_s;
  logic        clock_i, rst_n_i, txd_o, rts_o, dq_rx, dq_tx, rxd, cts;
  uflc_req_s   req;
  logic [31:0] rdata_o, d;
  logic [7:0]  irq_o, b;
  int          err_count = 0, n_tests = 0, cyc = 0;
  uflc_row_s   rows[8] = '{'{OFS_FSR, 32'h10404000}, '{OFS_ISR, 32'h2},
    '{OFS_BAUD, 32'h0f000000}, '{OFS_INFRARED_CONTROL, 32'h40}, '{OFS_IER, 32'h0},
    '{OFS_FCR, 32'h0}, '{OFS_LCR, 32'h0}, '{8'h40, 32'h0}};
  uflc_uart DUT (.clock_i, .rst_n_i, .reg_req_i(req), .rdata_o, .rxd_i(rxd), .cts_i(cts),
    .txd_o, .rts_o, .dma_rx_req_o(dq_rx), .dma_tx_req_o(dq_tx), .irq_o);
  uflc_peer peer (.clock_i, .txd_i(txd_o), .rxd_o(rxd), .cts_o(cts));
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("errors %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i);
    req <= '{a, v, 1'b1, 1'b0};
    @(posedge clock_i);
    req.wr <= 1'b0;
  endtask : wr
  // Read data stand one cycle only, so sample just after the taking edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock_i);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clock_i);
    req.rd <= 1'b0;
    #1 v = rdata_o;
  endtask : rd
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  always @(posedge clock_i) if (++cyc == 5000) begin
    err_count++;
    close_out();
  end
  initial begin
    req = '0;
    rst_n_i = 1'b0;
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].a, d);
      cmp(d, rows[i].v);
    end
    wr(OFS_LCR, 32'h3);
    wr(OFS_IER, 32'h6000);
    peer.cts_o <= 1'b1;
    wr(OFS_DATA, 32'ha5);
    repeat (100) @(posedge clock_i);
    cmp(txd_o, 1'b1);
    cmp(dq_tx, 1'b1);
    peer.cts_o <= 1'b0;
    peer.grab(b);
    cmp(b, 8'ha5);
    wr(OFS_IER, 32'h8001);
    peer.send(8'h3c);
    repeat (40) @(posedge clock_i);
    cmp(dq_rx, 1'b1);
    cmp(irq_o, 8'h01);
    rd(OFS_DATA, d);
    cmp(d, 32'h3c);
    peer.send(8'h77);
    repeat (40) @(posedge clock_i);
    wr(OFS_FCR, 32'h2);
    rd(OFS_FCR, d);
    cmp(d, 32'h2);
    repeat (5) @(posedge clock_i);
    rd(OFS_FCR, d);
    cmp(d, 32'h0);
    rd(OFS_DATA, d);
    cmp(d, 32'h0);
    wr(OFS_IER, 32'h1000);
    repeat (2) @(posedge clock_i);
    cmp(rts_o, 1'b0);
    peer.send(8'h11);
    repeat (40) @(posedge clock_i);
    cmp(rts_o, 1'b1);
    wr(OFS_LCR, 32'h43);
    repeat (3) @(posedge clock_i);
    cmp(txd_o, 1'b0);
    close_out();
  end
endmodule : tb

/* tb/uflc_peer.sv */
/* Serial peer model: drives rxd and cts, decodes txd as 8N1.
   Assumes 32 clocks per bit, the reset baud divisor. */
`timescale 1ns/10ps
module uflc_peer (
  input  wire logic clock_i,
  input  wire logic txd_i,
  output logic      rxd_o,
  output logic      cts_o
);
  localparam int BIT = 32;
  initial begin
    rxd_o = 1'b1;
    cts_o = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_o <= f[i];
      repeat (BIT) @(posedge clock_i);
    end
  endtask : send
  // Samples mid-bit; no framing check, only data
  task automatic grab(output logic [7:0] b);
    @(negedge txd_i);
    repeat (BIT / 2) @(posedge clock_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clock_i);
      b[i] = txd_i;
    end
  endtask : grab
endmodule : uflc_peer
